// [src/ckpio_pkg.sv]
// Constants, register map and types for the console keyboard/printer logic.
// Assumes a 40 MHz mclk and an AXI4-Lite master with 32-bit data.
package ckpio_pkg;
   localparam int CLK_MHZ = 40;
   localparam int STROBE_NS = 1000;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int NUM_KEYS = 62;
   localparam int CODE_W = 7;
   localparam int KEY_W = 6;
   localparam int COL_W = 7;
   localparam logic [6:0] LINE_LEN = 7'h48;
   // Register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TXD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ = 8'h0C;
   localparam logic [7:0] REG_MASK = 8'h10;
   localparam logic [7:0] REG_KEY = 8'h14;
   // CTRL fields
   localparam int CTL_HALT_UNPR = 0;
   localparam int CTL_ECHO = 1;
   localparam int CTL_WRAP = 2;
   localparam int CTL_BRK = 3;
   localparam int CTL_SKIP = 4;
   localparam int CTL_RESTART = 5;
   // IRQ fields
   localparam int IRQ_KEY = 0;
   localparam int IRQ_BRK = 1;
   localparam int IRQ_STOP = 2;
   localparam int IRQ_UNPR = 3;
   localparam int IRQ_W = 4;
   localparam logic [4:0] CTRL_RESET = 5'h01;
   // Character codes
   localparam logic [6:0] CH_SEMI = 7'h3B;
   localparam logic [6:0] CH_BRK = 7'h7E;
   localparam logic [6:0] CH_STOP = 7'h7F;
   localparam logic [6:0] CH_CR = 7'h0D;
   localparam logic [6:0] CH_PRINT_LO = 7'h20;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [1:0] {
      CKPIO_RUN = 2'b00,
      CKPIO_HALT_BRK = 2'b01,
      CKPIO_HALT_STOP = 2'b10,
      CKPIO_HALT_UNPR = 2'b11
   } ckpio_state_t;
endpackage : ckpio_pkg

// [src/ckpio_top.sv]
// Console keyboard encoder and printer output path with AXI4-Lite registers.
// Assumes key lines are asynchronous pins; the computer writes characters over AXI.
//
// Summary of operation
// - Each of 62 keys yields its own native character code.
// - Every key press pulses one shared strobe line.
// - Key code leaves on seven parallel lines.
// - Halt option set: unprintable code stalls the printer.
// - Halt option clear: unprintable code prints a semicolon.
// - Indicator shows sprocket always on plus seven code bits.
// - Echo option prints command symbols instead of executing them.
// - Wrap mode returns carriage when the line fills.
// - Otherwise carriage return only on the coded function character.
// - Breakpoint option makes breakpoint character stop the typewriter.
// - Breakpoint halt lights the breakpoint indicator.
// - Stop character halts and lights a separate stop indicator.
// - Print suppress inhibits all typewriter action.
// - Decoding still accepts every code while suppressed.
// - Keyboard characters are also printed as a copy.
`timescale 1ns/1ps
`default_nettype none
module ckpio_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ckpio_pkg::NUM_KEYS-1:0] key_pressed,
   output logic [ckpio_pkg::CODE_W-1:0] key_code,
   output logic key_strobe,
   output logic [ckpio_pkg::CODE_W:0] code_indicator,
   output logic brk_indicator,
   output logic stop_indicator,
   output logic [ckpio_pkg::CODE_W-1:0] type_char,
   output logic type_strike,
   output logic carriage_return,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic irq
);
   import ckpio_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Key synchroniser and encoder
   logic [NUM_KEYS-1:0] key_s1, key_s2, key_s3;
   logic [NUM_KEYS-1:0] next_key_s1, next_key_s2, next_key_s3;
   logic [CODE_W-1:0] next_key_code;
   logic [5:0] strobe_cnt, next_strobe_cnt;
   logic key_event;
   logic [CODE_W-1:0] enc_code;

   // Native coding: key n maps to code n+1, never zero
   always_comb begin
      enc_code = '0;
      key_event = 1'b0;
      for (int i = 0; i < NUM_KEYS; i++) begin
         if (key_s2[i] && !key_s3[i] && !key_event) begin
            enc_code = CODE_W'(i + 1);
            key_event = 1'b1;
         end
      end
   end

   always_comb begin
      next_key_s1 = key_pressed;
      next_key_s2 = key_s1;
      next_key_s3 = key_s2;
      next_key_code = key_event ? enc_code : key_code;
      next_strobe_cnt = strobe_cnt;
      if (key_event) begin
         next_strobe_cnt = 6'(STROBE_CYC);
      end else if (strobe_cnt != '0) begin
         next_strobe_cnt = strobe_cnt - 6'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         key_s1 <= '0;
         key_s2 <= '0;
         key_s3 <= '0;
         key_code <= '0;
         strobe_cnt <= '0;
      end else begin
         key_s1 <= next_key_s1;
         key_s2 <= next_key_s2;
         key_s3 <= next_key_s3;
         key_code <= next_key_code;
         strobe_cnt <= next_strobe_cnt;
      end
   end
   assign key_strobe = (strobe_cnt != '0);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   logic [4:0] ctrl, next_ctrl;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire, txd_write, restart;
   logic w_data_strb0, next_w_strb0;
   logic [CODE_W-1:0] txd_char;
   ckpio_state_t state, next_state;
   logic [IRQ_W-1:0] irq_set;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign txd_write = wr_fire && aw_addr == REG_TXD && w_data_strb0;
   assign txd_char = w_data[CODE_W-1:0];
   assign restart = wr_fire && aw_addr == REG_CTRL && w_data[CTL_RESTART];

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb0 = w_data_strb0;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OK;
         unique case (aw_addr)
            REG_CTRL: if (w_data_strb0) next_ctrl = w_data[4:0];
            REG_IRQ: if (w_data_strb0) next_irq_stat = irq_stat & ~w_data[IRQ_W-1:0];
            REG_MASK: if (w_data_strb0) next_irq_mask = w_data[IRQ_W-1:0];
            REG_TXD: ;
            default: next_bresp = RESP_ERR;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | irq_set;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OK;
         next_rdata = '0;
         unique case (s_axi_araddr)
            REG_CTRL: next_rdata[4:0] = ctrl;
            REG_TXD: next_rdata[CODE_W-1:0] = type_char;
            REG_STAT: next_rdata[1:0] = state;
            REG_IRQ: next_rdata[IRQ_W-1:0] = irq_stat;
            REG_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
            REG_KEY: next_rdata[CODE_W-1:0] = key_code;
            default: next_rresp = RESP_ERR;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_data_strb0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
         ctrl <= CTRL_RESET;
         irq_mask <= '0;
         irq_stat <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OK;
         s_axi_rdata <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_data_strb0 <= next_w_strb0;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         ctrl <= next_ctrl;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Printer decode
   logic char_in;
   logic [CODE_W-1:0] char_code;
   logic printable, is_cmd;
   logic [CODE_W-1:0] next_type_char;
   logic next_strike, next_cr, strike_raw, cr_raw;
   logic [COL_W-1:0] col, next_col;
   logic [CODE_W:0] next_ind;

   // Keyboard copy takes priority; a write in the same cycle is dropped
   assign char_in = txd_write || key_event;
   assign char_code = key_event ? enc_code : txd_char;
   assign printable = char_code >= CH_PRINT_LO;
   assign is_cmd = !printable && char_code != '0;

   always_comb begin
      next_state = state;
      next_type_char = type_char;
      strike_raw = 1'b0;
      cr_raw = 1'b0;
      next_col = col;
      next_ind = code_indicator;
      irq_set = '0;
      irq_set[IRQ_KEY] = key_event;
      if (restart) begin
         next_state = CKPIO_RUN;
      end else if (char_in && state == CKPIO_RUN) begin
         next_ind = {char_code, 1'b1};
         if (char_code == CH_STOP) begin
            next_state = CKPIO_HALT_STOP;
            irq_set[IRQ_STOP] = 1'b1;
         end else if (char_code == CH_BRK && ctrl[CTL_BRK]) begin
            next_state = CKPIO_HALT_BRK;
            irq_set[IRQ_BRK] = 1'b1;
         end else if (char_code == CH_CR && !ctrl[CTL_ECHO]) begin
            cr_raw = 1'b1;
            next_col = '0;
         end else if (is_cmd && ctrl[CTL_ECHO]) begin
            next_type_char = char_code;
            strike_raw = 1'b1;
            next_col = col + 7'h01;
         end else if (!printable) begin
            if (ctrl[CTL_HALT_UNPR]) begin
               next_state = CKPIO_HALT_UNPR;
               irq_set[IRQ_UNPR] = 1'b1;
            end else begin
               next_type_char = CH_SEMI;
               strike_raw = 1'b1;
               next_col = col + 7'h01;
            end
         end else begin
            next_type_char = char_code;
            strike_raw = 1'b1;
            next_col = col + 7'h01;
         end
         if (strike_raw && ctrl[CTL_WRAP] && next_col >= LINE_LEN) begin
            cr_raw = 1'b1;
            next_col = '0;
         end
      end
      next_strike = strike_raw && !ctrl[CTL_SKIP];
      next_cr = cr_raw && !ctrl[CTL_SKIP];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CKPIO_RUN;
         type_char <= '0;
         type_strike <= 1'b0;
         carriage_return <= 1'b0;
         col <= '0;
         code_indicator <= 8'h01;
      end else begin
         state <= next_state;
         type_char <= next_type_char;
         type_strike <= next_strike;
         carriage_return <= next_cr;
         col <= next_col;
         code_indicator <= next_ind;
      end
   end
   assign brk_indicator = (state == CKPIO_HALT_BRK);
   assign stop_indicator = (state == CKPIO_HALT_STOP);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_brk_seen;
      char_in && state == CKPIO_RUN && !restart && char_code == CH_BRK && ctrl[CTL_BRK];
   endsequence
   sequence s_stop_seen;
      char_in && state == CKPIO_RUN && !restart && char_code == CH_STOP;
   endsequence

   AST_KEY_CODE: assert property (@(posedge mclk) disable iff (rst)
      key_event |=> key_code == $past(enc_code) && key_code != '0)
      else $error("key code not presented");
   AST_STROBE: assert property (@(posedge mclk) disable iff (rst)
      key_event |=> key_strobe [*8])
      else $error("strobe too short");
   AST_UNPR_HALT: assert property (@(posedge mclk) disable iff (rst)
      (char_in && state == CKPIO_RUN && !restart && !printable && !is_cmd
       && ctrl[CTL_HALT_UNPR]) |=> state == CKPIO_HALT_UNPR && !type_strike)
      else $error("unprintable did not halt");
   AST_SEMI: assert property (@(posedge mclk) disable iff (rst)
      (char_in && state == CKPIO_RUN && !restart && !printable && !is_cmd
       && !ctrl[CTL_HALT_UNPR] && !ctrl[CTL_SKIP]) |=> type_strike && type_char == CH_SEMI)
      else $error("semicolon not printed");
   AST_SPROCKET: assert property (@(posedge mclk) disable iff (rst)
      code_indicator[0])
      else $error("sprocket indicator dark");
   AST_BRK: assert property (@(posedge mclk) disable iff (rst)
      s_brk_seen |=> brk_indicator && !stop_indicator)
      else $error("breakpoint halt missing");
   AST_STOP: assert property (@(posedge mclk) disable iff (rst)
      s_stop_seen |=> stop_indicator && !brk_indicator)
      else $error("stop halt missing");
   AST_SKIP: assert property (@(posedge mclk) disable iff (rst)
      $past(ctrl[CTL_SKIP]) |-> !type_strike && !carriage_return)
      else $error("typewriter moved while suppressed");
   AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
      (state != CKPIO_RUN && !restart) |=> $stable(state))
      else $error("halt released without restart");
endmodule : ckpio_top
`default_nettype wire

// [sim/ckpio_printer_model.sv]
// Typewriter-side recorder: counts strikes and carriage returns.
// Assumes single-cycle printer pulses sampled on mclk.
`timescale 1ns/1ps
`default_nettype none
module ckpio_printer_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [6:0] type_char,
   input wire logic type_strike,
   input wire logic carriage_return,
   output logic [15:0] strikes,
   output logic [15:0] crs,
   output logic [6:0] last_char
);
   // Tallies restart at reset so each scenario has a known base
   always_ff @(posedge mclk) begin
      if (rst) begin
         strikes <= '0;
         crs <= '0;
         last_char <= '0;
      end else begin
         if (type_strike === 1'b1) begin
            strikes <= strikes + 16'h1;
            last_char <= type_char;
         end
         if (carriage_return === 1'b1) begin
            crs <= crs + 16'h1;
         end
      end
   end
endmodule : ckpio_printer_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for ckpio_top: AXI4-Lite tasks, key presses, printer tally.
// Assumes the printer recorder watches the typewriter outputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ckpio_pkg::*;
   logic mclk, rst, awv, wv, bv, br, arv, arr, rv, rr, awr, wr_, irq, ks, cr, strike;
   logic brk_i, stp_i;
   logic [61:0] keys;
   logic [7:0] awa, ara, code_ind;
   logic [31:0] wd, rd;
   logic [3:0] ws;
   logic [1:0] bresp, rresp;
   logic [6:0] kcode, tchar, last_char;
   logic [15:0] strikes, crs;
   int fail_count, total_checks, cycles;
   ckpio_top ckpio_top_i (.mclk(mclk), .rst(rst), .key_pressed(keys), .key_code(kcode),
      .key_strobe(ks), .code_indicator(code_ind), .brk_indicator(brk_i),
      .stop_indicator(stp_i), .type_char(tchar), .type_strike(strike),
      .carriage_return(cr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .irq(irq));
   ckpio_printer_model ckpio_printer_model_i (.mclk(mclk), .rst(rst), .type_char(tchar),
      .type_strike(strike), .carriage_return(cr), .strikes(strikes), .crs(crs),
      .last_char(last_char));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         $display("Error %0t: timeout", $time);
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks hold each channel until its own ready is sampled high
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit done;
      done = 1'b0;
      @(posedge mclk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      br <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_ === 1'b1) wv <= 1'b0;
         if (bv === 1'b1) begin
            done = 1'b1;
            br <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
         end
      end
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      bit done;
      done = 1'b0;
      @(posedge mclk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      while (!done) begin
         @(posedge mclk);
         if (arr === 1'b1) arv <= 1'b0;
         if (rv === 1'b1) begin
            done = 1'b1;
            rr <= 1'b0;
            chk({30'h0, rresp}, {30'h0, er});
            if (er == RESP_OK) chk(rd, exp);
         end
      end
   endtask : rdc
   // Printer pulse lands one cycle after the write; three gives margin
   task automatic tx(input logic [6:0] c);
      wr(REG_TXD, {25'h0, c}, RESP_OK);
      repeat (3) @(posedge mclk);
   endtask : tx
   task automatic restart(input logic [31:0] c);
      wr(REG_CTRL, c | 32'h20, RESP_OK);
      wr(REG_CTRL, c, RESP_OK);
   endtask : restart
   task automatic press(input int k, input logic [6:0] exp);
      int n;
      @(posedge mclk);
      keys <= 62'h1 << k;
      n = 0;
      while (ks !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      while (ks === 1'b1) begin
         @(posedge mclk);
         n++;
      end
      chk(n, STROBE_CYC);
      chk({25'h0, kcode}, {25'h0, exp});
      keys <= '0;
      repeat (4) @(posedge mclk);
   endtask : press
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      keys = '0;
      {awv, wv, br, arv, rr} = '0;
      awa = '0;
      ara = '0;
      wd = '0;
      ws = 4'hF;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rdc(REG_CTRL, CTRL_RESET, RESP_OK);
      chk(code_ind, 32'h1);
      rdc(8'h40, 32'h0, RESP_ERR);
      tx(7'h41);
      chk(last_char, 32'h41);
      chk(code_ind, 32'h83);
      tx(7'h00);
      rdc(REG_STAT, 32'h3, RESP_OK);
      chk(strikes, 32'h1);
      tx(7'h42);
      chk(strikes, 32'h1);
      restart(32'h0);
      rdc(REG_STAT, 32'h0, RESP_OK);
      tx(7'h00);
      chk(last_char, CH_SEMI);
      tx(CH_CR);
      chk(crs, 32'h1);
      chk(strikes, 32'h2);
      wr(REG_CTRL, 32'h2, RESP_OK);
      tx(CH_CR);
      chk(last_char, CH_CR);
      chk(crs, 32'h1);
      wr(REG_CTRL, 32'h10, RESP_OK);
      tx(7'h43);
      chk(strikes, 32'h3);
      chk(code_ind, 32'h87);
      wr(REG_CTRL, 32'h8, RESP_OK);
      tx(CH_BRK);
      chk(brk_i, 32'h1);
      chk(stp_i, 32'h0);
      rdc(REG_STAT, 32'h1, RESP_OK);
      tx(7'h44);
      chk(strikes, 32'h3);
      chk(brk_i, 32'h1);
      chk(irq, 32'h0);
      restart(32'h0);
      chk(brk_i, 32'h0);
      tx(CH_STOP);
      chk(stp_i, 32'h1);
      chk(brk_i, 32'h0);
      rdc(REG_STAT, 32'h2, RESP_OK);
      restart(32'h0);
      tx(CH_CR);
      repeat (73) tx(7'h41);
      chk(crs, 32'h2);
      wr(REG_CTRL, 32'h4, RESP_OK);
      tx(CH_CR);
      repeat (73) tx(7'h41);
      chk(crs, 32'h4);
      wr(REG_CTRL, 32'h0, RESP_OK);
      wr(REG_IRQ, 32'hF, RESP_OK);
      wr(REG_MASK, 32'h1, RESP_OK);
      // Lane 0 strobe off: the write is answered but must not land
      ws <= 4'hE;
      wr(REG_MASK, 32'hF, RESP_OK);
      ws <= 4'hF;
      rdc(REG_MASK, 32'h1, RESP_OK);
      chk(irq, 32'h0);
      for (int k = 0; k < NUM_KEYS; k++) begin
         press(k, 7'(k + 1));
      end
      chk(last_char, 32'h3E);
      rdc(REG_KEY, 32'h3E, RESP_OK);
      chk(irq, 32'h1);
      wr(REG_IRQ, 32'h1, RESP_OK);
      repeat (2) @(posedge mclk);
      chk(irq, 32'h0);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
